// File: src/pwrseq_defs.svh
`ifndef PWRSEQ_DEFS_SVH
`define PWRSEQ_DEFS_SVH

// Debounce time in microseconds and derived cycle count at 200 MHz
`define PWRSEQ_CLK_MHZ 200
`define PWRSEQ_DEBOUNCE_US 10
`define PWRSEQ_DEBOUNCE_CYC (`PWRSEQ_DEBOUNCE_US * `PWRSEQ_CLK_MHZ)
// Settle time for module supplies and for carrier supplies, microseconds
`define PWRSEQ_SETTLE_US 100
`define PWRSEQ_SETTLE_CYC (`PWRSEQ_SETTLE_US * `PWRSEQ_CLK_MHZ)
`define PWRSEQ_CNT_W 16

`endif

// File: src/pwrseq_pkg.sv
`default_nettype none
package pwrseq_pkg;
   typedef enum logic [2:0] {
      ST_OFF      = 3'h0,
      ST_MOD_PWR  = 3'h1,
      ST_WAIT_BTN = 3'h2,
      ST_CARRIER  = 3'h3,
      ST_RUN      = 3'h4,
      ST_SUSPEND  = 3'h5
   } seq_state_t;

   // Debounced carrier-side inputs, all active high after inversion
   typedef struct packed {
      logic power_good;
      logic reset_req;
      logic button;
   } carrier_in_t;
endpackage : pwrseq_pkg
`default_nettype wire

// File: src/module_power_up_sequencer.sv
// Notes on behaviour
// R1: Module power on only while fault line high
// R2: Carrier holds fault line low until stable
// R3: Await button event before carrier power
// R4: Carrier power: assert supply enable and standby
// R5: Release reset after carrier power, then boot
// R6: Supply enable active high, after own supplies
// R7: Standby low signals suspend entry
// R8: Carrier may drop supplies in standby
// R9: Reset request low forces module reset
// R10: Reset output held low during sequencing
// R11: Button wakes from or shuts to S5
// R12: Synchronise and debounce carrier inputs
`include "pwrseq_defs.svh"
`default_nettype none
module module_power_up_sequencer #(
   parameter int DEBOUNCE_CYC = `PWRSEQ_DEBOUNCE_CYC,
   parameter int SETTLE_CYC = `PWRSEQ_SETTLE_CYC,
   parameter bit BUTTON_USED = 1'b1
) (
   input wire logic i_sys_clk,               // 200 MHz clock
   input wire logic i_rst,                   // Sync reset, active high
   input wire logic i_input_power_fault_n,   // Low: input supply not good
   input wire logic i_reset_request_n,       // Carrier reset request, low active
   input wire logic i_power_button_n,        // Carrier power button, low active
   input wire logic i_suspend_req,           // Enter suspend, same clock domain
   output logic o_module_power_en,           // Module internal regulators on
   output logic o_carrier_supply_enable,     // Carrier main power, high active
   output logic o_carrier_standby_n,         // Low while suspended
   output logic o_reset_out_n,               // Module reset to carrier
   output logic o_power_button_event_n       // One-cycle low on debounced press
);
   localparam int CW = `PWRSEQ_CNT_W;

   // Boot states: reset released toward the carrier
   function automatic logic is_booted(input pwrseq_pkg::seq_state_t s);
      return s == pwrseq_pkg::ST_RUN || s == pwrseq_pkg::ST_SUSPEND;
   endfunction : is_booted

   // R12: two-flop synchronisers
   // Pins are asynchronous here; the flops need no reset as reset outlasts them
   logic [2:0] meta_q, sync_q;
   always_ff @(posedge i_sys_clk) begin
      meta_q <= {~i_input_power_fault_n, ~i_reset_request_n, ~i_power_button_n};
      sync_q <= meta_q;
   end

   // R12: debounce, level taken once stable for DEBOUNCE_CYC
   pwrseq_pkg::carrier_in_t deb_q;
   logic [2:0] deb_bits;
   assign deb_bits = {~deb_q.power_good, deb_q.reset_req, deb_q.button};
   logic [2:0] deb_next;
   // Counter restarts whenever the pin agrees again, so a short glitch leaves no trace
   for (genvar g = 0; g < 3; g++) begin : g_deb
      logic [CW-1:0] cnt_q;
      wire differs = sync_q[g] != deb_bits[g];
      wire stable = cnt_q == CW'(DEBOUNCE_CYC - 1);
      always_ff @(posedge i_sys_clk) begin
         if (i_rst || !differs) begin
            cnt_q <= '0;
         end else if (!stable) begin
            cnt_q <= cnt_q + CW'(1);
         end
      end
      assign deb_next[g] = (differs && stable) ? sync_q[g] : deb_bits[g];
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         deb_q <= '0;
      end else begin
         deb_q <= '{power_good: ~deb_next[2], reset_req: deb_next[1], button: deb_next[0]};
      end
   end

   logic btn_prev_q;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         btn_prev_q <= 1'b0;
      end else begin
         btn_prev_q <= deb_q.button;
      end
   end
   wire btn_press = deb_q.button && !btn_prev_q;

   pwrseq_pkg::seq_state_t state_q, state_d;
   logic [CW-1:0] tmr_q;
   wire tmr_done = tmr_q == CW'(SETTLE_CYC - 1);
   // R1: fault low or R9: reset request forces back to off
   // Outranks every state, suspend included, so a cut supply always restarts
   wire force_off = !deb_q.power_good || deb_q.reset_req;

   always_comb begin
      state_d = state_q;
      case (state_q)
         pwrseq_pkg::ST_OFF: begin
            if (deb_q.power_good && !deb_q.reset_req) begin
               state_d = pwrseq_pkg::ST_MOD_PWR;
            end
         end
         // R6: carrier enabled only after own supplies settle
         pwrseq_pkg::ST_MOD_PWR: begin
            if (tmr_done) begin
               state_d = BUTTON_USED ? pwrseq_pkg::ST_WAIT_BTN : pwrseq_pkg::ST_CARRIER;
            end
         end
         // R3: wait for press before carrier power; R11 wake from S5
         pwrseq_pkg::ST_WAIT_BTN: begin
            if (btn_press) begin
               state_d = pwrseq_pkg::ST_CARRIER;
            end
         end
         // R5: release reset once carrier supplies settle
         pwrseq_pkg::ST_CARRIER: begin
            if (tmr_done) begin
               state_d = pwrseq_pkg::ST_RUN;
            end
         end
         // R11: press shuts down to soft off
         pwrseq_pkg::ST_RUN: begin
            if (BUTTON_USED && btn_press) begin
               state_d = pwrseq_pkg::ST_WAIT_BTN;
            end else if (i_suspend_req) begin
               state_d = pwrseq_pkg::ST_SUSPEND;
            end
         end
         pwrseq_pkg::ST_SUSPEND: begin
            if (!i_suspend_req || btn_press) begin
               state_d = pwrseq_pkg::ST_RUN;
            end
         end
         // Unused codes fall back to off, the safe side for the carrier
         default: state_d = pwrseq_pkg::ST_OFF;
      endcase
      if (force_off) begin
         state_d = pwrseq_pkg::ST_OFF;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_q <= pwrseq_pkg::ST_OFF;
         tmr_q <= '0;
      end else begin
         state_q <= state_d;
         // One timer serves both settle phases; it restarts on every state change
         tmr_q <= (state_d != state_q || tmr_done) ? '0 : tmr_q + CW'(1);
      end
   end

   // Decoded outputs, registered so nothing glitches toward the carrier
   wire st_on = state_d != pwrseq_pkg::ST_OFF;
   wire booted = is_booted(state_d);
   wire carrier_on = state_d == pwrseq_pkg::ST_CARRIER || booted;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         // Carrier unpowered and module held in reset
         o_module_power_en <= 1'b0;
         o_carrier_supply_enable <= 1'b0;
         o_carrier_standby_n <= 1'b0;
         o_reset_out_n <= 1'b0;
         o_power_button_event_n <= 1'b1;
      end else begin
         // R1: regulators on in every state except off, so a reset request also drops them
         o_module_power_en <= st_on;
         // R4: both carrier controls together
         o_carrier_supply_enable <= carrier_on;
         // R7: standby low in suspend
         o_carrier_standby_n <= carrier_on && state_d != pwrseq_pkg::ST_SUSPEND;
         // R10: reset held until running
         o_reset_out_n <= booted;
         o_power_button_event_n <= !btn_press;
      end
   end

   // R5: reset released only with carrier power up
   chk_reset_after_carrier: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R5
      o_reset_out_n |-> o_carrier_supply_enable) else $error("reset released without carrier power");
   chk_fault_drops_power: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R1
      !deb_q.power_good |=> !o_module_power_en) else $error("power on with fault");
   chk_carrier_needs_module: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R6
      o_carrier_supply_enable |-> o_module_power_en) else $error("carrier before module");
   chk_standby_pairs: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R4
      o_carrier_standby_n |-> o_carrier_supply_enable) else $error("standby without supply");
   chk_reset_req_resets: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R9
      deb_q.reset_req |=> !o_reset_out_n) else $error("reset request ignored");
   chk_suspend_standby: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R7
      state_q == pwrseq_pkg::ST_SUSPEND |-> !o_carrier_standby_n) else $error("suspend not shown");
   chk_seq_holds_reset: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R10
      (state_q == pwrseq_pkg::ST_MOD_PWR || state_q == pwrseq_pkg::ST_CARRIER) |-> !o_reset_out_n)
      else $error("reset released while sequencing");
   chk_button_wakes: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R3
      (state_q == pwrseq_pkg::ST_WAIT_BTN && !btn_press && !force_off) |=> state_q == pwrseq_pkg::ST_WAIT_BTN)
      else $error("left soft off without press");
   chk_debounce_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R12
      $changed(deb_q.button) |-> $past(sync_q[0]) == deb_q.button) else $error("debounce took wrong level");
   chk_shutdown: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R11
      (state_q == pwrseq_pkg::ST_RUN && btn_press && !force_off && BUTTON_USED) |=> !o_carrier_supply_enable)
      else $error("button did not shut down");

   // R4: supply enable and standby rise together
   chk_carrier_pair: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R4
      $rose(o_carrier_supply_enable) |-> o_carrier_standby_n) else $error("carrier controls not paired");
   // R5: boot only from a powered carrier
   chk_boot_after_power: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R5
      $rose(o_reset_out_n) |-> $past(o_carrier_supply_enable)) else $error("boot without carrier power");
   // R11: button event lasts one cycle
   chk_event_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R11
      !o_power_button_event_n |=> o_power_button_event_n) else $error("button event too long");
   // R1: nothing powered in off state
   chk_off_unpowered: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R1
      state_q == pwrseq_pkg::ST_OFF |-> !o_module_power_en && !o_carrier_supply_enable) else $error("power while off");
   // R3: carrier stays off awaiting press
   chk_wait_no_carrier: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R3
      state_q == pwrseq_pkg::ST_WAIT_BTN |-> !o_carrier_supply_enable) else $error("carrier on before press");
   // R7: suspend keeps supply on and reset released
   chk_suspend_powered: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R7
      state_q == pwrseq_pkg::ST_SUSPEND |-> o_carrier_supply_enable && o_reset_out_n) else $error("suspend lost power");

   // Main scenarios

   cov_boot: cover property (@(posedge i_sys_clk) $rose(o_reset_out_n));
   cov_suspend: cover property (@(posedge i_sys_clk) $fell(o_carrier_standby_n) && o_carrier_supply_enable);
   cov_shutdown: cover property (@(posedge i_sys_clk) $fell(o_carrier_supply_enable) && o_module_power_en);
   cov_fault: cover property (@(posedge i_sys_clk) $fell(o_module_power_en));
   cov_reset_request: cover property (@(posedge i_sys_clk) $fell(o_reset_out_n) && deb_q.reset_req);
endmodule : module_power_up_sequencer
`default_nettype wire

// File: sim/carrier_model.sv
`default_nettype none
module carrier_model #(
   parameter int STABLE_CYC = 6
) (
   input wire logic i_sys_clk,       // Bench clock
   input wire logic i_supply_ok,     // Input rail in range
   input wire logic i_reset_cmd,     // Pull reset request low
   input wire logic i_press_cmd,     // Hold button down
   input wire logic i_standby_n,     // Standby from module
   output var logic o_fault_n,       // Fault line to module
   output logic o_reset_request_n,   // Open drain, pulled up
   output logic o_power_button_n,    // Open drain, pulled up
   output logic o_aux_rail_on        // Rail cut in standby
);
   timeunit 1ns;
   timeprecision 1ps;
   int stable_cnt = 0;
   always @(negedge i_sys_clk) begin
      stable_cnt <= i_supply_ok ? stable_cnt + 1 : 0;
      o_fault_n <= i_supply_ok && stable_cnt >= STABLE_CYC;
   end
   // Released drains read as the pull-up level
   assign o_reset_request_n = ~i_reset_cmd;
   assign o_power_button_n = ~i_press_cmd;
   assign o_aux_rail_on = i_standby_n;
endmodule : carrier_model
`default_nettype wire

// File: sim/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic supply_ok = 1'b0;
   logic rst_cmd = 1'b0;
   logic press = 1'b0;
   logic susp = 1'b0;
   wire fault_n;
   wire req_n;
   wire btn_n;
   wire [4:0] outs;
   wire [4:0] outs_auto;
   wire aux_on;
   int failures = 0;
   int cmp_count = 0;
   initial forever #2.5 clk = ~clk;
   carrier_model #(.STABLE_CYC(6)) i_carrier (.i_sys_clk(clk), .i_supply_ok(supply_ok), .i_reset_cmd(rst_cmd),
      .i_press_cmd(press), .i_standby_n(outs[2]), .o_fault_n(fault_n), .o_reset_request_n(req_n),
      .o_power_button_n(btn_n), .o_aux_rail_on(aux_on));
   module_power_up_sequencer #(.DEBOUNCE_CYC(4), .SETTLE_CYC(8), .BUTTON_USED(1'b1)) i_dut (.i_sys_clk(clk),
      .i_rst(rst), .i_input_power_fault_n(fault_n), .i_reset_request_n(req_n), .i_power_button_n(btn_n),
      .i_suspend_req(susp), .o_module_power_en(outs[4]), .o_carrier_supply_enable(outs[3]),
      .o_carrier_standby_n(outs[2]), .o_reset_out_n(outs[1]), .o_power_button_event_n(outs[0]));
   // Second instance without a button: the carrier comes up unattended
   module_power_up_sequencer #(.DEBOUNCE_CYC(4), .SETTLE_CYC(8), .BUTTON_USED(1'b0)) i_dut_auto (.i_sys_clk(clk),
      .i_rst(rst), .i_input_power_fault_n(fault_n), .i_reset_request_n(req_n), .i_power_button_n(btn_n),
      .i_suspend_req(susp), .o_module_power_en(outs_auto[4]), .o_carrier_supply_enable(outs_auto[3]),
      .o_carrier_standby_n(outs_auto[2]), .o_reset_out_n(outs_auto[1]), .o_power_button_event_n(outs_auto[0]));
   task automatic check(input logic [4:0] seen, input logic [4:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Bounded wait; a miss shows up as a mismatch
   task automatic wait_bit(input int idx, input logic val);
      int n;
      n = 0;
      while (outs[idx] !== val && n < 60) begin
         @(negedge clk);
         n++;
      end
      check({4'h0, outs[idx]}, {4'h0, val});
   endtask : wait_bit
   task automatic press_btn(input logic [4:0] exp);
      press = 1'b1;
      wait_bit(0, 1'b0);
      check(outs, exp);
      @(negedge clk);
      press = 1'b0;
      check(outs, exp | 5'h01);
   endtask : press_btn
   task automatic t_power_up;
      repeat (30) @(negedge clk);
      check(outs, 5'h01);
      supply_ok = 1'b1;
      wait_bit(4, 1'b1);
      check(outs, 5'h11);
      repeat (40) @(negedge clk);
      check(outs, 5'h11);
      check(outs_auto, 5'h1F);
      press_btn(5'h1C);
      wait_bit(1, 1'b1);
      check(outs, 5'h1F);
      $display("power-up test done");
   endtask : t_power_up
   task automatic t_suspend;
      susp = 1'b1;
      wait_bit(2, 1'b0);
      check(outs, 5'h1B);
      check({4'h0, aux_on}, 5'h00);
      susp = 1'b0;
      wait_bit(2, 1'b1);
      check(outs, 5'h1F);
      check({4'h0, aux_on}, 5'h01);
      $display("suspend test done");
   endtask : t_suspend
   task automatic t_button_off;
      press_btn(5'h10);
      repeat (20) @(negedge clk);
      check(outs, 5'h11);
      press_btn(5'h1C);
      wait_bit(1, 1'b1);
      check(outs, 5'h1F);
      $display("button test done");
   endtask : t_button_off
   task automatic t_reset_req;
      rst_cmd = 1'b1;
      repeat (2) @(negedge clk);
      rst_cmd = 1'b0;
      repeat (20) @(negedge clk);
      check(outs, 5'h1F);
      rst_cmd = 1'b1;
      wait_bit(1, 1'b0);
      check(outs, 5'h01);
      rst_cmd = 1'b0;
      wait_bit(4, 1'b1);
      check(outs, 5'h11);
      check(outs_auto, 5'h11);
      supply_ok = 1'b0;
      wait_bit(4, 1'b0);
      check(outs, 5'h01);
      check(outs_auto, 5'h01);
      $display("reset and fault test done");
   endtask : t_reset_req
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_power_up;
      t_suspend;
      t_button_off;
      t_reset_req;
      stop_test;
   end
   initial begin
      repeat (3000) @(negedge clk);
      failures++;
      stop_test;
   end
endmodule : tb
`default_nettype wire
